// *** hdl/bwd_top.sv ***
// Board watchdog supervisor with APB register access and event interrupt.
// Assumes one 200 MHz clock and a synchronous active-low board reset.
//
// Notes on behaviour
// [RQ1] The watchdog is off after reset and runs only once software sets its start bit.
// [RQ2] Software picks the timeout action before it starts the watchdog.
// [RQ3] In reset mode a missed kick pulses the board reset output.
// [RQ4] In interrupt mode a missed kick raises the processor interrupt line.
// [RQ5] A timeout sets a sticky flag that software reads in the status register.
// [RQ6] Writing the key to the option register pulses the board reset and clears the flag.
// [RQ7] Starting in reset mode while the flag is set gives an immediate reset.
// [RQ8] Starting in interrupt mode while the flag is set raises the interrupt at once.
// [RQ9] The interrupt output drives the processor external interrupt line, set up by software.
// [RQ10] The interrupt handler checks the flag and then writes the key to clear it.
// [RQ11] After startup software checks the flag and issues the keyed reset if it is set.
// [RQ12] Any change of the kick bit restarts the timeout window.
// [RQ13] Writing zero to the start bit cannot stop a running watchdog.
// [RQ14] Action select 0 means board reset, 1 means interrupt.
// [RQ15] The timeout window is a parameter in clock cycles from start or last kick.
`timescale 1ns/10ps
`default_nettype none
module bwd_top
  import bwd_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // APB slave.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Board side.
  output logic BOARD_RESETN_O,
  output logic CPU_EXTERNAL_IRQ_LINE_O,
  // Event interrupt.
  output logic IRQ_O
);

  typedef struct packed
  {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    bwd_wd_state_t wd;
    logic timeout_action_select;
    logic kick_toggle_bit;
    logic timeout_flag;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic board_rstn;
    logic nmi;
    logic [NEV-1:0] evt_stat;
    logic [NEV-1:0] evt_en;
    logic irq;
  } bwd_state_t;

  localparam bwd_state_t RST_VAL = '{
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0,
    wd: BWD_OFF,
    timeout_action_select: ACT_RESET,
    kick_toggle_bit: 1'b0,
    timeout_flag: 1'b0,
    rst_cnt: '0,
    board_rstn: 1'b1,
    nmi: 1'b0,
    evt_stat: '0,
    evt_en: '0,
    irq: 1'b0
  };

  bwd_state_t s_r;
  bwd_state_t s_nxt;

  logic expire;
  logic restart;
  logic wd_run;

  // Timeout window counter.
  bwd_timer
  #(
    .LIMIT(TIMEOUT_CYCLES)
  )
  u_timer
  (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .run_i(wd_run),
    .restart_i(restart),
    .expire_o(expire)
  );

  // Address decode helpers.
  logic [5:0] idx;
  logic hit;
  logic wr;
  logic [7:0] wb;
  logic [31:0] rd;

  assign idx = PADDR_I[7:2];
  assign wb = PWDATA_I[7:0];
  assign hit = (PADDR_I[1:0] == 2'b00) &&
    (idx == CTRL_IDX || idx == OPTID_IDX || idx == SETUP_IDX ||
     idx == STAT_IDX || idx == EVT_STAT_IDX || idx == EVT_CLR_IDX ||
     idx == EVT_EN_IDX);
  // A write lands at the completing access edge, only on lane 0.
  assign wr = PSEL_I && PENABLE_I && s_r.pready && PWRITE_I && PSTRB_I[0] && hit;
  assign wd_run = (s_r.wd == BWD_RUN);

  // Read multiplexer; write-only and unmapped words read as zero.
  always_comb
  begin
    rd = 32'h0;
    case (idx)
      CTRL_IDX:
      begin
        rd[CTRL_ACT_BIT] = s_r.timeout_action_select;
        rd[CTRL_KICK_BIT] = s_r.kick_toggle_bit;
      end
      OPTID_IDX:
      begin
        rd[7:0] = OPTION_ID;
      end
      SETUP_IDX:
      begin
        rd[SETUP_EN_BIT] = (s_r.wd != BWD_OFF);
      end
      STAT_IDX:
      begin
        rd[STAT_FLAG_N_BIT] = ~s_r.timeout_flag; // RQ5
      end
      EVT_STAT_IDX:
      begin
        rd[NEV-1:0] = s_r.evt_stat;
      end
      EVT_EN_IDX:
      begin
        rd[NEV-1:0] = s_r.evt_en;
      end
      default:
      begin
        rd = 32'h0;
      end
    endcase
  end

  // Write side effects as single-cycle strobes.
  logic kick_w;
  logic start_w;
  logic key_w;
  logic [NEV-1:0] clr_w;

  always_comb
  begin
    kick_w = 1'b0;
    start_w = 1'b0;
    key_w = 1'b0;
    clr_w = '0;
    if (wr)
    begin
      case (idx)
        CTRL_IDX:
        begin
          kick_w = (wb[CTRL_KICK_BIT] != s_r.kick_toggle_bit); // RQ12
        end
        OPTID_IDX:
        begin
          key_w = (wb == RESET_KEY); // RQ6
        end
        SETUP_IDX:
        begin
          // A zero is simply ignored, so writing it cannot stop a running watchdog.
          start_w = wb[SETUP_EN_BIT]; // RQ13
        end
        EVT_CLR_IDX:
        begin
          clr_w = wb[NEV-1:0];
        end
        default:
        begin
          kick_w = 1'b0;
        end
      endcase
    end
  end

  // Window restarts on a kick while running or on a fresh start.
  assign restart = (wd_run && kick_w) || (s_r.wd == BWD_OFF && start_w); // RQ15

  // Next-state logic for bus, watchdog and events.
  logic flag_set;
  logic reset_req;
  logic [NEV-1:0] ev;

  always_comb
  begin
    s_nxt = s_r;
    flag_set = 1'b0;
    reset_req = 1'b0;
    ev = '0;

    // Zero-wait APB: ready in the access phase after every setup cycle.
    s_nxt.pready = PSEL_I && !PENABLE_I;
    s_nxt.pslverr = PSEL_I && !PENABLE_I && !hit;
    if (PSEL_I && !PENABLE_I)
    begin
      s_nxt.prdata = (hit && !PWRITE_I) ? rd : 32'h0;
    end

    // Plain register writes.
    if (wr && idx == CTRL_IDX)
    begin
      s_nxt.timeout_action_select = wb[CTRL_ACT_BIT]; // RQ14
      s_nxt.kick_toggle_bit = wb[CTRL_KICK_BIT];
    end
    if (wr && idx == EVT_EN_IDX)
    begin
      s_nxt.evt_en = wb[NEV-1:0];
    end

    // Watchdog sequence.
    case (s_r.wd)
      BWD_OFF:
      begin
        if (start_w) // RQ1
        begin
          ev[EV_START] = 1'b1;
          if (s_r.timeout_flag && s_r.timeout_action_select == ACT_RESET)
          begin
            reset_req = 1'b1; // RQ7
          end
          else if (s_r.timeout_flag)
          begin
            s_nxt.wd = BWD_TRIP; // RQ8
          end
          else
          begin
            s_nxt.wd = BWD_RUN;
          end
        end
      end
      BWD_RUN:
      begin
        if (expire)
        begin
          flag_set = 1'b1; // RQ5
          ev[EV_TIMEOUT] = 1'b1;
          if (s_r.timeout_action_select == ACT_RESET)
          begin
            // The board is reset, so the watchdog stops with it; the flag stays.
            reset_req = 1'b1; // RQ3
            s_nxt.wd = BWD_OFF;
          end
          else
          begin
            s_nxt.wd = BWD_TRIP; // RQ4
          end
        end
      end
      BWD_TRIP:
      begin
        s_nxt.wd = BWD_TRIP;
      end
      default:
      begin
        s_nxt.wd = BWD_OFF;
      end
    endcase

    // Keyed full reset; a timeout in the same cycle still leaves the flag set.
    if (key_w)
    begin
      reset_req = 1'b1; // RQ6
      s_nxt.wd = BWD_OFF;
      ev[EV_KEYRST] = 1'b1;
    end
    s_nxt.timeout_flag = flag_set || (s_r.timeout_flag && !key_w);

    // Board reset pulse of fixed length.
    if (reset_req)
    begin
      s_nxt.rst_cnt = RST_CNT_W'(RST_PULSE_CYC);
    end
    else if (s_r.rst_cnt != '0)
    begin
      s_nxt.rst_cnt = s_r.rst_cnt - 1'b1;
    end
    s_nxt.board_rstn = (s_nxt.rst_cnt == '0);

    // The interrupt line stays high while tripped, until a keyed reset.
    s_nxt.nmi = (s_nxt.wd == BWD_TRIP); // RQ9

    // Sticky events: a new event wins over a clear in the same cycle.
    s_nxt.evt_stat = (s_r.evt_stat & ~clr_w) | ev;
    s_nxt.irq = |(s_nxt.evt_stat & s_nxt.evt_en);
  end

  // State register.
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I)
    begin
      s_r <= RST_VAL;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign PRDATA_O = s_r.prdata;
  assign PREADY_O = s_r.pready;
  assign PSLVERR_O = s_r.pslverr;
  assign BOARD_RESETN_O = s_r.board_rstn;
  assign CPU_EXTERNAL_IRQ_LINE_O = s_r.nmi;
  assign IRQ_O = s_r.irq;

endmodule
`default_nettype wire

// *** hdl/bwd_pkg.sv ***
// Constants, field layout and state types of the board watchdog supervisor.
// Assumes a single 200 MHz board logic clock and a 32-bit APB register bus.
package bwd_pkg;

  // Clock rate and timing figures.
  localparam int CLK_MHZ = 200;
  localparam int TIMEOUT_MS = 1000;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int RST_PULSE_NS = 1000;
  // A least time, so the cycle count rounds up.
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_CNT_W = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] CTRL_IDX = 6'h01;
  localparam logic [5:0] OPTID_IDX = 6'h04;
  localparam logic [5:0] SETUP_IDX = 6'h05;
  localparam logic [5:0] STAT_IDX = 6'h08;
  localparam logic [5:0] EVT_STAT_IDX = 6'h0c;
  localparam logic [5:0] EVT_CLR_IDX = 6'h0d;
  localparam logic [5:0] EVT_EN_IDX = 6'h0e;

  // Field positions.
  localparam int CTRL_ACT_BIT = 5;
  localparam int CTRL_KICK_BIT = 6;
  localparam int SETUP_EN_BIT = 6;
  localparam int STAT_FLAG_N_BIT = 0;
  localparam int EV_TIMEOUT = 0;
  localparam int EV_KEYRST = 1;
  localparam int EV_START = 2;
  localparam int NEV = 3;

  // Values.
  localparam logic [7:0] RESET_KEY = 8'ha5;
  // Option identification value; arbitrary.
  localparam logic [7:0] OPTION_ID = 8'h3c;
  localparam logic ACT_RESET = 1'b0;
  localparam logic ACT_NMI = 1'b1;

  // Watchdog states, Gray coded along off, run, tripped.
  typedef enum logic [1:0]
  {
    BWD_OFF = 2'b00,
    BWD_RUN = 2'b01,
    BWD_TRIP = 2'b11
  } bwd_wd_state_t;

endpackage

// *** hdl/bwd_timer.sv ***
// Timeout window counter of the board watchdog.
// Assumes its controls come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module bwd_timer
#(
  parameter int LIMIT = 16
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control.
  input wire logic run_i,
  input wire logic restart_i,
  // Result.
  output logic expire_o
);

  localparam logic [31:0] LAST = 32'(LIMIT - 1);

  typedef struct packed
  {
    logic [31:0] cnt;
    logic expire;
  } bwd_tmr_t;

  bwd_tmr_t s_r;
  bwd_tmr_t s_nxt;

  // Count while running; a restart or a stop empties the window.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.expire = 1'b0;
    if (!run_i || restart_i)
    begin
      s_nxt.cnt = 32'h0;
    end
    else if (s_r.cnt == LAST)
    begin
      s_nxt.cnt = 32'h0;
      s_nxt.expire = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end

  // State register.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign expire_o = s_r.expire;

endmodule
`default_nettype wire

// *** sim/bwd_checker.sv ***
// Checker of the watchdog: bus timing, board reset pulse and interrupt line.
// Assumes it is bound to bwd_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module bwd_checker
  import bwd_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 50
)
(
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Bus.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Board side.
  input wire logic BOARD_RESETN_O,
  input wire logic CPU_EXTERNAL_IRQ_LINE_O
);
  logic wr_w;
  logic key_w;
  logic [15:0] idle_r;
  // A completed write, and the keyed reset among them.
  assign wr_w = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  assign key_w = wr_w && PADDR_I == {OPTID_IDX, 2'b00} && PWDATA_I[7:0] == RESET_KEY;
  // Cycles since a write that may start, kick or reset; it saturates so it never wraps.
  always_ff @(posedge CLK_I)
  begin
    if (!RESETN_I || (wr_w && PADDR_I[7:4] < 4'h2))
    begin
      idle_r <= 16'h0000;
    end
    else if (idle_r != 16'hffff)
    begin
      idle_r <= idle_r + 16'h0001;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  // The board reset stays low for its full length, then lets go.
  sequence s_low_run;
    ##199 !BOARD_RESETN_O ##1 BOARD_RESETN_O;
  endsequence
  a_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("ready missing");
  a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready too long");
  a_err_misaligned: assert property (PREADY_O && PADDR_I[1:0] != 2'h0 |-> PSLVERR_O)
    else $error("misaligned not refused");
  a_key_resets: assert property (key_w |=> !BOARD_RESETN_O)
    else $error("key gave no reset");
  a_pulse_length: assert property ($fell(BOARD_RESETN_O) |-> s_low_run)
    else $error("reset pulse length");
  a_reset_timing: assert property ($fell(BOARD_RESETN_O) |->
    idle_r <= 16'h0001 || idle_r >= TIMEOUT_CYCLES - 2)
    else $error("reset at wrong time");
  a_line_timing: assert property ($rose(CPU_EXTERNAL_IRQ_LINE_O) |->
    idle_r <= 16'h0001 || idle_r >= TIMEOUT_CYCLES - 2)
    else $error("line at wrong time");
  a_line_sticky: assert property (CPU_EXTERNAL_IRQ_LINE_O && !key_w
    |=> CPU_EXTERNAL_IRQ_LINE_O)
    else $error("line dropped");
endmodule
bind bwd_top bwd_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk
(
  .CLK_I(CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .BOARD_RESETN_O(BOARD_RESETN_O),
  .CPU_EXTERNAL_IRQ_LINE_O(CPU_EXTERNAL_IRQ_LINE_O)
);
`default_nettype wire

// *** sim/bwd_host.sv ***
// Host processor model: bus master and the interrupt input it watches.
// Assumes the bench calls its task; each transfer starts at the next edge.
`timescale 1ns/10ps
`default_nettype none
module bwd_host
(
  // Clock.
  input wire logic clk_i,
  // Bus master side.
  output var logic psel_o = 1'b0,
  output var logic penable_o = 1'b0,
  output var logic pwrite_o = 1'b0,
  output var logic [7:0] paddr_o = 8'h00,
  output var logic [31:0] pwdata_o = 32'h00000000,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  // External interrupt input.
  input wire logic irq_line_i
);
  logic seen_r = 1'b0;
  // The input is set up as a level request; remember that it fired.
  always @(posedge clk_i)
  begin
    if (irq_line_i === 1'b1)
    begin
      seen_r <= 1'b1;
    end
  end
  // One transfer; the request holds until ready is sampled high.
  // There is no wait limit here, so only the bench's watchdog ends a hang.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/test_board_watchdog.sv ***
// Self-checking bench of the board watchdog supervisor.
// Assumes a 50-cycle timeout window so that the run stays short.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin #1; checks++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
module test_board_watchdog import bwd_pkg::*;;
  localparam int TO = 50;
  logic CLK_I = 1'b0;
  logic RESETN_I = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, brst_n, line, irq, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int checks = 0;
  int mismatches = 0;
  always #2.5 CLK_I = ~CLK_I;
  bwd_host host (.clk_i(CLK_I), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .irq_line_i(line));
  bwd_top #(.TIMEOUT_CYCLES(TO)) uut (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PSTRB_I(4'hf), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .BOARD_RESETN_O(brst_n), .CPU_EXTERNAL_IRQ_LINE_O(line), .IRQ_O(irq));
  // Byte-wide register access; data sits in the low byte.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h000000, d}, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h00000000, q, e);
  endtask
  // Waits out a board reset pulse so that the next request is not mid-pulse.
  task automatic pulse_end;
    repeat (210) if (!brst_n) @(posedge CLK_I);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // A hang counts as a mismatch.
  initial
  begin
    #20000;
    mismatches++;
    finish_test();
  end
  // Test sequence.
  initial
  begin
    repeat (2) @(posedge CLK_I);
    RESETN_I <= 1'b1;
    rd(8'h14);
    `CHK("setup", 32'h0, q)
    rd(8'h20);
    `CHK("status", 32'h1, q)
    rd(8'h10);
    `CHK("option", {24'h0, OPTION_ID}, q)
    rd(8'h3c);
    `CHK("unmapped", 1'b1, e)
    wr(8'h12, RESET_KEY);
    `CHK("misaligned", 1'b1, e)
    repeat (2 * TO) @(posedge CLK_I);
    `CHK("idle", 1'b1, brst_n)
    $display("test idle done");
    wr(8'h04, 8'h00);
    wr(8'h14, 8'h40);
    wr(8'h14, 8'h00);
    rd(8'h14);
    `CHK("running", 32'h40, q)
    for (int i = 0; i < 4; i++)
    begin
      repeat (TO - 15) @(posedge CLK_I);
      wr(8'h04, i % 2 ? 8'h00 : 8'h40);
    end
    `CHK("kicked", 1'b1, brst_n)
    repeat (TO + 10) if (brst_n) @(posedge CLK_I);
    `CHK("timeout", 1'b0, brst_n)
    rd(8'h20);
    `CHK("flag", 32'h0, q)
    pulse_end();
    rd(8'h14);
    `CHK("stopped", 32'h0, q)
    wr(8'h14, 8'h40);
    `CHK("again", 1'b0, brst_n)
    pulse_end();
    $display("test reset mode done");
    wr(8'h04, 8'h20);
    wr(8'h14, 8'h40);
    repeat (4) if (!line) @(posedge CLK_I);
    `CHK("line again", 1'b1, line)
    rd(8'h20);
    `CHK("handler", 32'h0, q)
    wr(8'h10, RESET_KEY);
    `CHK("key", 1'b0, brst_n)
    rd(8'h20);
    `CHK("cleared", 32'h1, q)
    `CHK("line off", 1'b0, line)
    pulse_end();
    rd(8'h20);
    `CHK("startup", 32'h1, q)
    $display("test key done");
    rd(8'h30);
    `CHK("ev all", 32'h7, q)
    wr(8'h34, 8'h07);
    wr(8'h38, 8'h01);
    `CHK("irq idle", 1'b0, irq)
    wr(8'h04, 8'h20);
    wr(8'h14, 8'h40);
    repeat (TO + 10) if (!line) @(posedge CLK_I);
    `CHK("line", 1'b1, line)
    `CHK("no reset", 1'b1, brst_n)
    rd(8'h30);
    `CHK("events", 32'h5, q)
    `CHK("irq on", 1'b1, irq)
    wr(8'h38, 8'h00);
    rd(8'h30);
    `CHK("masked", 1'b0, irq)
    wr(8'h38, 8'h01);
    wr(8'h34, 8'h01);
    rd(8'h30);
    `CHK("ev clear", 32'h4, q)
    `CHK("irq off", 1'b0, irq)
    `CHK("host", 1'b1, host.seen_r)
    $display("test interrupt done");
    finish_test();
  end
endmodule
`default_nettype wire
